// >>> clock_gen_pkg.sv
// constants shared by the clock generator register block
// assumes a 32-bit classic wishbone slave on sys_clk
package clock_gen_pkg;

    // register byte addresses, one aligned word each
    localparam logic [4:0] ADDR_LOOP_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_BANDWIDTH_MODE = 5'h04;
    localparam logic [4:0] ADDR_FACTOR_HIGH = 5'h08;
    localparam logic [4:0] ADDR_FACTOR_LOW = 5'h0c;
    localparam logic [4:0] ADDR_RANGE_SEL = 5'h10;
    localparam logic [4:0] ADDR_REF_DIV_SEL = 5'h14;

    // loop_control bit positions
    localparam int IE_BIT = 7;
    localparam int FLAG_BIT = 6;
    localparam int ON_BIT = 5;
    localparam int BCS_BIT = 4;
    localparam int PRE_LSB = 2;
    localparam int EXP_LSB = 0;

    // bandwidth_mode_control bit positions
    localparam int AUTO_BIT = 7;
    localparam int LOCK_BIT = 6;
    localparam int TRACK_BIT = 5;

    // reset values, then the zero and one values used by the substitution and range checks
    localparam logic [11:0] FACTOR_RESET = 12'h040;
    localparam logic [7:0] RANGE_RESET = 8'h40;
    localparam logic [3:0] REF_DIV_RESET = 4'h1;
    localparam logic [11:0] FACTOR_ZERO = 12'h000;
    localparam logic [11:0] FACTOR_ONE = 12'h001;
    localparam logic [3:0] REF_DIV_ZERO = 4'h0;
    localparam logic [3:0] REF_DIV_ONE = 4'h1;
    localparam logic [7:0] RANGE_ZERO = 8'h00;

    // source edges waited on each side of a switchover
    localparam logic [1:0] SWITCH_EDGES = 2'h3;

    typedef enum logic [2:0] {
        SEL_RUN = 3'b001,
        SEL_DRAIN = 3'b010,
        SEL_FILL = 3'b100
    } sel_state_t;

endpackage : clock_gen_pkg

// >>> clock_gen_regs.sv
// register file, lock flag logic and base clock selector of the clock generator
// assumes osc_clock, vco_clock, lock_status and track_status are sampled on sys_clk,
// which must run well above both source clocks
//
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps

// Summary of operation
// R1 - lock_irq_enable ignores writes and reads 0 in manual mode; reset clears it.
// R2 - every lock indicator toggle sets lock_change_flag; with enable, raises lock_irq.
// R3 - lock_change_flag reads 0 in manual mode, so no interrupt then.
// R4 - any loop_control read clears lock_change_flag; reset clears it too; here a lock toggle in the same cycle as the read keeps it set.
// R5 - loop_power_on cannot be cleared while base_clock_select is 1.
// R6 - reset sets loop_power_on so the loop settles during power-up.
// R7 - base_clock_select cannot be set while loop_power_on is 0; reset clears it.
// R8 - after select change the base clock holds static over three old, three new edges.
// R9 - base clock is selected source halved, 50 percent duty; 1 picks divided VCO.
// R10 - prescaler field writable only with loop off; reset 0; multiplier two to P.
// R11 - VCO exponent field writable only with loop off; reset 0; software avoids 3.
// R12 - auto bit: 1 automatic, 0 manual bandwidth control; reset manual.
// R13 - lock indicator read-only, follows lock in automatic mode, reads 0 in manual.
// R14 - software always writes 0 to the lock indicator position.
// R15 - track bit is status in automatic mode, writable loop mode control in manual.
// R16 - manual track value is kept through automatic mode; reset means acquisition.
// R17 - twelve-bit feedback factor resets to 0x040; zero acts as one.
// R18 - feedback factor registers ignore writes while loop_power_on is 1.
// R19 - VCO linear range writable only with loop off; resets to 0x40.
// R20 - linear range zero disables loop, clears and blocks base_clock_select.
// R21 - four-bit reference divider writable only with loop off; reset 1; zero acts as one.
// R22 - one write cannot both toggle the loop and switch to or from divided VCO; here a write of ON 0, BCS 1 with the loop on does both.
// R23 - divided VCO clock is VCO over two to P; bus clock quarter of source.
// R24 - lock indicator comes from lock_status, synchronised before toggle detection.
module clock_gen_regs #(
    parameter int FACTOR_W = 12,
    parameter int REF_DIV_W = 4
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic osc_clock,
    input wire logic vco_clock,
    input wire logic lock_status,
    input wire logic track_status,
    output logic lock_irq,
    output logic base_clock_out,
    output logic bus_clock_out,
    output logic divided_vco_clock,
    output logic loop_enable,
    output logic track_mode,
    output logic [1:0] vco_divider_power,
    output logic [1:0] vco_band_exponent,
    output logic [FACTOR_W-1:0] feedback_factor_eff,
    output logic [7:0] vco_linear_range,
    output logic [REF_DIV_W-1:0] ref_divide_eff
);

    initial
    begin
        if (FACTOR_W != 12 || REF_DIV_W != 4)
            $error("clock_gen_regs: field widths are fixed by the register layout");
    end

    logic lock_irq_enable;
    logic lock_change_flag;
    logic loop_power_on;
    logic base_clock_select;
    logic auto_mode;
    logic track_manual;
    logic [FACTOR_W-1:0] feedback_factor;
    logic [REF_DIV_W-1:0] ref_divide_factor;
    logic lock_meta;
    logic lock_sync;
    logic lock_prev;
    logic track_meta;
    logic track_sync;
    logic lock_toggle;
    logic lock_indicator;
    logic access;
    logic wr;
    logic rd_loop_control;
    logic wr_loop_control;
    logic range_zero;
    logic next_on;
    logic next_bcs;
    logic [31:0] next_dat;
    logic [2:0] vco_count;
    logic vco_prev;
    logic osc_prev;
    logic div_prev;
    logic next_divided;
    logic osc_rise;
    logic div_rise;
    logic active_sel;
    logic [1:0] edge_count;
    logic old_rise;
    logic new_rise;
    logic base_prev;
    clock_gen_pkg::sel_state_t sel_state;

    function automatic logic [31:0] zero_ext8(input logic [7:0] v);
        zero_ext8 = {24'h00_0000, v};
    endfunction : zero_ext8

    // bus decode; ack registered so writes land on the edge before the master sees ack
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = access && wb_we_i && wb_sel_i[0];
    assign rd_loop_control = access && !wb_we_i && wb_adr_i == clock_gen_pkg::ADDR_LOOP_CONTROL;
    assign wr_loop_control = wr && wb_adr_i == clock_gen_pkg::ADDR_LOOP_CONTROL;
    assign range_zero = vco_linear_range == clock_gen_pkg::RANGE_ZERO;

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= access;
    end

    // lock and track status synchronisers
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
            lock_prev <= 1'b0;
            track_meta <= 1'b0;
            track_sync <= 1'b0;
        end
        else
        begin
            lock_meta <= lock_status;
            lock_sync <= lock_meta; // [R24]
            lock_prev <= lock_indicator;
            track_meta <= track_status;
            track_sync <= track_meta;
        end
    end

    assign lock_indicator = auto_mode && lock_sync; // [R13]
    assign lock_toggle = lock_indicator != lock_prev; // [R24]
    assign track_mode = auto_mode ? track_sync : track_manual; // [R15]

    // flag: a toggle in the same cycle as a clearing read wins
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            lock_change_flag <= 1'b0; // [R4]
        else if (lock_toggle)
            lock_change_flag <= 1'b1; // [R2]
        else if (rd_loop_control)
            lock_change_flag <= 1'b0; // [R4]
    end

    assign lock_irq = lock_change_flag && lock_irq_enable && auto_mode; // [R2] [R3]

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            lock_irq_enable <= 1'b0; // [R1]
        else if (wr_loop_control && auto_mode)
            lock_irq_enable <= wb_dat_i[clock_gen_pkg::IE_BIT]; // [R1]
    end

    // loop on / base select interlock
    always_comb
    begin
        next_on = loop_power_on;
        next_bcs = base_clock_select;
        if (wr_loop_control)
        begin
            // current select blocks clearing the loop, current loop blocks setting select,
            // yet a write of ON 0 and BCS 1 with the loop on and select 0 turns both over together
            next_on = wb_dat_i[clock_gen_pkg::ON_BIT] || base_clock_select; // [R5] [R22]
            next_bcs = wb_dat_i[clock_gen_pkg::BCS_BIT] && loop_power_on; // [R7] [R22]
        end
        if (range_zero)
            next_bcs = 1'b0; // [R20]
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            loop_power_on <= 1'b1; // [R6]
            base_clock_select <= 1'b0; // [R7]
        end
        else
        begin
            loop_power_on <= next_on;
            base_clock_select <= next_bcs;
        end
    end

    assign loop_enable = loop_power_on && !range_zero; // [R20]

    // fields frozen while the loop runs
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            vco_divider_power <= 2'h0; // [R10]
            vco_band_exponent <= 2'h0; // [R11]
        end
        else if (wr_loop_control && !loop_power_on)
        begin
            vco_divider_power <= wb_dat_i[clock_gen_pkg::PRE_LSB +: 2]; // [R10]
            vco_band_exponent <= wb_dat_i[clock_gen_pkg::EXP_LSB +: 2]; // [R11]
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            feedback_factor <= clock_gen_pkg::FACTOR_RESET; // [R17]
            vco_linear_range <= clock_gen_pkg::RANGE_RESET; // [R19]
            ref_divide_factor <= clock_gen_pkg::REF_DIV_RESET; // [R21]
        end
        else if (wr && !loop_power_on)
        begin
            case (wb_adr_i)
                clock_gen_pkg::ADDR_FACTOR_HIGH:
                    feedback_factor[11:8] <= wb_dat_i[3:0]; // [R18]
                clock_gen_pkg::ADDR_FACTOR_LOW:
                    feedback_factor[7:0] <= wb_dat_i[7:0]; // [R18]
                clock_gen_pkg::ADDR_RANGE_SEL:
                    vco_linear_range <= wb_dat_i[7:0]; // [R19]
                clock_gen_pkg::ADDR_REF_DIV_SEL:
                    ref_divide_factor <= wb_dat_i[3:0]; // [R21]
                default:
                    ;
            endcase
        end
    end

    assign feedback_factor_eff = (feedback_factor == clock_gen_pkg::FACTOR_ZERO) ?
        clock_gen_pkg::FACTOR_ONE : feedback_factor; // [R17]
    assign ref_divide_eff = (ref_divide_factor == clock_gen_pkg::REF_DIV_ZERO) ?
        clock_gen_pkg::REF_DIV_ONE : ref_divide_factor; // [R21]

    // bandwidth control; the manual track value survives automatic mode untouched
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            auto_mode <= 1'b0; // [R12]
            track_manual <= 1'b0; // [R16]
        end
        else if (wr && wb_adr_i == clock_gen_pkg::ADDR_BANDWIDTH_MODE)
        begin
            auto_mode <= wb_dat_i[clock_gen_pkg::AUTO_BIT]; // [R12]
            if (!auto_mode)
                track_manual <= wb_dat_i[clock_gen_pkg::TRACK_BIT]; // [R15] [R16]
        end
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        next_dat = 32'h0000_0000;
        case (wb_adr_i)
            clock_gen_pkg::ADDR_LOOP_CONTROL:
                next_dat = zero_ext8({lock_irq_enable && auto_mode, lock_change_flag && auto_mode,
                    loop_power_on, base_clock_select, vco_divider_power, vco_band_exponent}); // [R1] [R3]
            clock_gen_pkg::ADDR_BANDWIDTH_MODE:
                next_dat = zero_ext8({auto_mode, lock_indicator, track_mode, 5'h00}); // [R13] [R14]
            clock_gen_pkg::ADDR_FACTOR_HIGH:
                next_dat = zero_ext8({4'h0, feedback_factor[11:8]});
            clock_gen_pkg::ADDR_FACTOR_LOW:
                next_dat = zero_ext8(feedback_factor[7:0]);
            clock_gen_pkg::ADDR_RANGE_SEL:
                next_dat = zero_ext8(vco_linear_range);
            clock_gen_pkg::ADDR_REF_DIV_SEL:
                next_dat = zero_ext8({4'h0, ref_divide_factor});
            default:
                next_dat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
            wb_dat_o <= 32'h0000_0000;
        else if (access && !wb_we_i)
            wb_dat_o <= next_dat;
    end

    // vco prescaler, stopped with the loop
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            vco_prev <= 1'b0;
            vco_count <= 3'h0;
        end
        else
        begin
            vco_prev <= vco_clock && loop_enable;
            if (vco_clock && loop_enable && !vco_prev)
                vco_count <= vco_count + 3'h1;
        end
    end

    always_comb
    begin
        case (vco_divider_power)
            2'h0: next_divided = vco_clock && loop_enable; // [R23]
            2'h1: next_divided = vco_count[0];
            2'h2: next_divided = vco_count[1];
            default: next_divided = vco_count[2];
        endcase
        // a stopped loop must not leave a frozen high count bit on the output
        if (!loop_enable)
            next_divided = 1'b0; // [R23]
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            divided_vco_clock <= 1'b0;
            osc_prev <= 1'b0;
            div_prev <= 1'b0;
        end
        else
        begin
            divided_vco_clock <= next_divided; // [R23]
            osc_prev <= osc_clock;
            div_prev <= divided_vco_clock;
        end
    end

    assign osc_rise = osc_clock && !osc_prev;
    // a stopped loop counts as ticking, so a switch away from it cannot stall forever
    assign div_rise = (divided_vco_clock && !div_prev) || !loop_enable; // [R8]
    assign old_rise = active_sel ? div_rise : osc_rise;
    assign new_rise = active_sel ? osc_rise : div_rise;

    // switchover: output frozen while old source drains and new source fills
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            sel_state <= clock_gen_pkg::SEL_RUN;
            active_sel <= 1'b0;
            edge_count <= 2'h0;
        end
        else
        begin
            case (sel_state)
                clock_gen_pkg::SEL_RUN:
                    if (base_clock_select != active_sel)
                    begin
                        sel_state <= clock_gen_pkg::SEL_DRAIN; // [R8]
                        edge_count <= 2'h0;
                    end
                clock_gen_pkg::SEL_DRAIN:
                    if (old_rise)
                    begin
                        if (edge_count == clock_gen_pkg::SWITCH_EDGES - 2'h1)
                        begin
                            sel_state <= clock_gen_pkg::SEL_FILL;
                            edge_count <= 2'h0;
                        end
                        else
                            edge_count <= edge_count + 2'h1;
                    end
                clock_gen_pkg::SEL_FILL:
                    if (new_rise)
                    begin
                        if (edge_count == clock_gen_pkg::SWITCH_EDGES - 2'h1)
                        begin
                            sel_state <= clock_gen_pkg::SEL_RUN; // [R8]
                            active_sel <= !active_sel;
                            edge_count <= 2'h0;
                        end
                        else
                            edge_count <= edge_count + 2'h1;
                    end
                default:
                    sel_state <= clock_gen_pkg::SEL_RUN;
            endcase
        end
    end

    // halving on rising edges gives 50 percent duty whatever the source duty
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            base_clock_out <= 1'b0;
            base_prev <= 1'b0;
            bus_clock_out <= 1'b0;
        end
        else
        begin
            if (sel_state == clock_gen_pkg::SEL_RUN && base_clock_select == active_sel && old_rise)
                base_clock_out <= !base_clock_out; // [R9]
            base_prev <= base_clock_out;
            if (base_clock_out && !base_prev)
                bus_clock_out <= !bus_clock_out; // [R23]
        end
    end

    sequence s_select_differs;
        sel_state == clock_gen_pkg::SEL_RUN && base_clock_select != active_sel;
    endsequence

    sequence s_frozen;
        sel_state != clock_gen_pkg::SEL_RUN;
    endsequence

    a_ie_manual_read: assert property (@(posedge sys_clk) disable iff (!rstn) // [R1]
        rd_loop_control && !auto_mode |=> !wb_dat_o[clock_gen_pkg::IE_BIT])
        else $error("interrupt enable read as one in manual mode");

    a_flag_on_toggle: assert property (@(posedge sys_clk) disable iff (!rstn) // [R2]
        lock_toggle |=> lock_change_flag)
        else $error("lock toggle did not set the change flag");

    a_flag_manual_read: assert property (@(posedge sys_clk) disable iff (!rstn) // [R3]
        rd_loop_control && !auto_mode |=> !wb_dat_o[clock_gen_pkg::FLAG_BIT] && !lock_irq)
        else $error("change flag visible in manual mode");

    a_read_clears_flag: assert property (@(posedge sys_clk) disable iff (!rstn) // [R4]
        rd_loop_control && !lock_toggle |=> !lock_change_flag)
        else $error("control read left the change flag set");

    a_loop_kept_on: assert property (@(posedge sys_clk) disable iff (!rstn) // [R5]
        base_clock_select |=> loop_power_on)
        else $error("loop cleared while base select was set");

    a_select_needs_loop: assert property (@(posedge sys_clk) disable iff (!rstn) // [R7]
        $rose(base_clock_select) |-> $past(loop_power_on) && !range_zero)
        else $error("base select set with loop off");

    a_switch_starts: assert property (@(posedge sys_clk) disable iff (!rstn) // [R8]
        s_select_differs |=> s_frozen)
        else $error("switchover did not start");

    a_base_static: assert property (@(posedge sys_clk) disable iff (!rstn) // [R8]
        s_frozen |=> $stable(base_clock_out))
        else $error("base clock moved during switchover");

    a_prescaler_locked: assert property (@(posedge sys_clk) disable iff (!rstn) // [R10]
        loop_power_on |=> $stable(vco_divider_power) && $stable(vco_band_exponent))
        else $error("prescaler or exponent changed with loop on");

    a_factor_locked: assert property (@(posedge sys_clk) disable iff (!rstn) // [R18]
        loop_power_on |=> $stable(feedback_factor) && $stable(ref_divide_factor))
        else $error("divider setting changed with loop on");

    a_range_zero_off: assert property (@(posedge sys_clk) disable iff (!rstn) // [R20]
        range_zero |=> !base_clock_select && !loop_enable)
        else $error("zero range left the loop selectable");

endmodule : clock_gen_regs

// >>> analog_loop_model.sv
// behavioural far side of the clock generator: source clocks, lock level, base clock consumer
// assumes sys_clk runs far above both source clocks, which are levels sampled on it
`timescale 1ns/1ps
module analog_loop_model (
    input wire logic sys_clk,
    input wire logic lock_req,
    input wire logic base_clock_out,
    output logic osc_clock,
    output logic vco_clock,
    output logic lock_status,
    output logic track_status,
    output int base_toggles
);
    logic [2:0] phase = 3'h0;
    logic base_q = 1'b0;

    // osc at an eighth, vco at a quarter of sys_clk, so the two rates are easy to tell apart
    always @(posedge sys_clk)
    begin
        phase <= phase + 3'h1;
    end
    assign osc_clock = phase[2];
    assign vco_clock = phase[1];

    // lock follows the bench; tracking status stays at acquisition
    assign lock_status = lock_req;
    assign track_status = 1'b0;

    // consumer counts base clock transitions; only differences are used
    always @(posedge sys_clk)
    begin
        base_q <= base_clock_out;
        if (base_q !== base_clock_out)
        begin
            base_toggles <= base_toggles + 1;
        end
    end
endmodule : analog_loop_model

// >>> pll_clock_gen_registers_bench.sv
// self-checking bench for the clock generator register block
// assumes the analog loop model on the far side and a classic wishbone master here
`timescale 1ns/1ps
module pll_clock_gen_registers_bench;
    localparam logic [4:0] LC = clock_gen_pkg::ADDR_LOOP_CONTROL;
    localparam logic [4:0] BW = clock_gen_pkg::ADDR_BANDWIDTH_MODE;
    localparam logic [4:0] FH = clock_gen_pkg::ADDR_FACTOR_HIGH;
    localparam logic [4:0] FL = clock_gen_pkg::ADDR_FACTOR_LOW;
    localparam logic [4:0] RS = clock_gen_pkg::ADDR_RANGE_SEL;
    localparam logic [4:0] RD = clock_gen_pkg::ADDR_REF_DIV_SEL;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [4:0] wb_adr = 5'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic lock_req = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, osc_clock, vco_clock, lock_status, track_status, lock_irq;
    logic base_clock_out, loop_enable, track_mode, bus_clock_out, divided_vco_clock;
    logic bus_q = 1'b0;
    logic [7:0] vco_linear_range;
    int bus_toggles = 0;
    logic [1:0] vco_divider_power, vco_band_exponent;
    logic [11:0] feedback_factor_eff;
    logic [3:0] ref_divide_eff;
    int base_toggles;
    int errors = 0;
    int num_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    clock_gen_regs clock_gen_regs_i (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .osc_clock(osc_clock), .vco_clock(vco_clock), .lock_status(lock_status),
        .track_status(track_status), .lock_irq(lock_irq), .base_clock_out(base_clock_out),
        .bus_clock_out(bus_clock_out), .divided_vco_clock(divided_vco_clock), .loop_enable(loop_enable),
        .track_mode(track_mode),
        .vco_divider_power(vco_divider_power), .vco_band_exponent(vco_band_exponent),
        .feedback_factor_eff(feedback_factor_eff), .vco_linear_range(vco_linear_range),
        .ref_divide_eff(ref_divide_eff));

    // bus clock transitions, counted like the base clock in the far-side model
    always @(posedge sys_clk)
    begin
        bus_q <= bus_clock_out;
        if (bus_q !== bus_clock_out)
            bus_toggles <= bus_toggles + 1;
    end

    analog_loop_model analog_loop_model_i (.sys_clk(sys_clk), .lock_req(lock_req),
        .base_clock_out(base_clock_out), .osc_clock(osc_clock), .vco_clock(vco_clock),
        .lock_status(lock_status), .track_status(track_status), .base_toggles(base_toggles));

    task test_done;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    task fail(input string m);
        errors++;
        $display("CHECK FAILED t=%0t %s", $time, m);
    endtask : fail

    task check_reg(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
            fail($sformatf("reg got %h exp %h", got, exp));
    endtask : check_reg

    task check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
            fail($sformatf("bit got %b exp %b", got, exp));
    endtask : check_bit

    // request held until ack is sampled high, released at that edge
    task wb_xfer(input logic [4:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_dat <= {24'h00_0000, d};
        n = 0;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk);
            n++;
        end
        q = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 20)
        begin
            fail("bus timeout");
            test_done();
        end
    endtask : wb_xfer

    task wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb_xfer(a, 1'b1, d, q);
    endtask : wr

    task rd(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] q;
        wb_xfer(a, 1'b0, 8'h00, q);
        check_reg(q, exp);
    endtask : rd

    // fixed window after settling; switchover time is bounded well inside the settle
    task rate_chk(input int lo, input int hi);
        int s;
        int b;
        repeat (60) @(posedge sys_clk);
        s = base_toggles;
        b = bus_toggles;
        repeat (160) @(posedge sys_clk);
        check_bit((base_toggles - s) inside {[lo:hi]}, 1'b1);
        check_bit((bus_toggles - b) inside {[lo / 2:(hi + 1) / 2]}, 1'b1);
    endtask : rate_chk

    initial
    begin
        int n;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(LC, 8'h20);
        rd(BW, 8'h00);
        rd(FH, 8'h00);
        rd(FL, 8'h40);
        rd(RS, 8'h40);
        rd(RD, 8'h01);
        rd(5'h18, 8'h00);
        wr(FL, 8'h55);
        wr(RS, 8'h11);
        wr(RD, 8'h07);
        wr(LC, 8'h2e);
        rd(FL, 8'h40);
        rd(RS, 8'h40);
        rd(RD, 8'h01);
        rd(LC, 8'h20);
        wr(LC, 8'ha0);
        rd(LC, 8'h20);
        rate_chk(19, 21);
        wr(LC, 8'h30);
        wr(LC, 8'h10);
        rd(LC, 8'h30);
        rate_chk(38, 42);
        wr(LC, 8'h20);
        rd(LC, 8'h20);
        rate_chk(19, 21);
        wr(BW, 8'h80);
        wr(LC, 8'ha0);
        rd(LC, 8'ha0);
        lock_req <= 1'b1;
        n = 0;
        while (lock_irq !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk);
            n++;
        end
        check_bit(lock_irq, 1'b1);
        rd(BW, 8'hc0);
        rd(LC, 8'he0);
        rd(LC, 8'ha0);
        check_bit(lock_irq, 1'b0);
        wr(BW, 8'h00);
        rd(LC, 8'h20);
        check_bit(lock_irq, 1'b0);
        wr(BW, 8'h20);
        rd(BW, 8'h20);
        check_bit(track_mode, 1'b1);
        wr(BW, 8'ha0);
        rd(BW, 8'hc0);
        check_bit(track_mode, 1'b0);
        wr(BW, 8'h00);
        rd(BW, 8'h20);
        wr(LC, 8'h00);
        rd(LC, 8'h00);
        wr(LC, 8'h10);
        rd(LC, 8'h00);
        // exponent kept below 3 on purpose
        wr(LC, 8'h0e);
        rd(LC, 8'h0e);
        check_bit(divided_vco_clock, 1'b0);
        check_reg({4'h0, vco_divider_power, vco_band_exponent}, 8'h0e);
        wr(FH, 8'h00);
        wr(FL, 8'h00);
        rd(FL, 8'h00);
        check_bit(feedback_factor_eff === 12'h001, 1'b1);
        wr(RD, 8'h00);
        check_bit(ref_divide_eff === 4'h1, 1'b1);
        wr(RS, 8'h00);
        check_reg(vco_linear_range, 8'h00);
        wr(LC, 8'h30);
        rd(LC, 8'h20);
        wr(LC, 8'h30);
        rd(LC, 8'h20);
        check_bit(loop_enable, 1'b0);
        test_done();
    end
endmodule : pll_clock_gen_registers_bench
